// ---- tlic_map.svh ----
// Purpose: Addresses, reset values and field positions of the controller
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// ==========================================================
// Register addresses and reset values
`define TLIC_EN_ADDR 8'ha8
`define TLIC_X2_ADDR 8'ha9
`define TLIC_TS_ADDR 8'hb8
`define TLIC_WDC_ADDR 8'hc0
`define TLIC_EN_RST 8'h00
`define TLIC_TS_RST 8'h00
`define TLIC_X2_RST 8'ha0
`define TLIC_WDC_RST 8'h10
`define TLIC_X2_RSV 8'ha0
`define TLIC_ZERO8 8'h00

// ==========================================================
// Enable register fields
`define TLIC_EN_GATE 7
`define TLIC_EN_TEMP 6
`define TLIC_EN_T2 5
`define TLIC_EN_UART 4
`define TLIC_EN_T1 3
`define TLIC_EN_X1 2
`define TLIC_EN_T0 1
`define TLIC_EN_X0 0

// ==========================================================
// Second enable/tier register fields
`define TLIC_X2_TK_TIER 6
`define TLIC_X2_SP_TIER 4
`define TLIC_X2_MET_EN 3
`define TLIC_X2_IT_EN 2
`define TLIC_X2_PM_EN 1
`define TLIC_X2_SP_EN 0

// ==========================================================
// Tier register fields and watchdog flag
`define TLIC_TS_MET 7
`define TLIC_TS_TEMP 6
`define TLIC_TS_T2 5
`define TLIC_TS_UART 4
`define TLIC_TS_T1 3
`define TLIC_TS_X1 2
`define TLIC_TS_T0 1
`define TLIC_TS_X0 0
`define TLIC_WDC_FLAG 2

// ==========================================================
// Source slots in polling order
`define TLIC_NSRC 12
`define TLIC_S_PM 0
`define TLIC_S_IT 1
`define TLIC_S_MET 2
`define TLIC_S_WD 3
`define TLIC_S_TEMP 4
`define TLIC_S_X0 5
`define TLIC_S_T0 6
`define TLIC_S_X1 7
`define TLIC_S_T1 8
`define TLIC_S_SP 9
`define TLIC_S_UART 10
`define TLIC_S_T2 11
`define TLIC_TOP_MASK 12'h001
`define TLIC_ONE12 12'h001

`endif

// ---- tlic_pkg.sv ----
// Purpose: Types shared by the interrupt controller files
// Assumes: Nothing
// Notes: Constants live in tlic_map.svh
package tlic_pkg;
  // ==========================================================
  // Tiers, lowest first
  typedef enum logic [1:0] {TIER_LOW, TIER_HIGH, TIER_TOP} tlic_tier_t;

  // Offer made to the core
  typedef struct packed {
    logic valid;
    tlic_tier_t tier;
    logic [3:0] src;
  } tlic_offer_t;

  // Byte access to a register
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_sfr_t;

  // Single-bit access by bit address
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic val;
  } tlic_bit_t;
endpackage

// ---- tlic_sync.sv ----
// Purpose: Three-stage filter for the external request pins
// Assumes: Pins are asynchronous to i_clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tlic_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [1:0] i_pin,
  output logic [1:0] o_lvl
);
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] lvl_ff;
  wire logic [1:0] agree = ~(s2_ff ^ s3_ff);
  wire logic [1:0] nxt_lvl = (agree & s3_ff) | (~agree & lvl_ff);

  // ==========================================================
  // Stage one feeds stage two only, to contain metastability
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_ff <= 2'h0;
      s2_ff <= 2'h0;
      s3_ff <= 2'h0;
      lvl_ff <= 2'h0;
    end else if (i_ce) begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign o_lvl = lvl_ff;
endmodule // tlic_sync
`default_nettype wire

// ---- tlic_poll.sv ----
// Purpose: Fixed polling pick within one tier
// Assumes: Bit 0 is polled first
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module tlic_poll (
  input wire logic [11:0] i_req,
  output logic o_found,
  output logic [3:0] o_idx
);
  // ==========================================================
  // Walk down so the lowest slot is written last and wins
  always_comb begin
    o_found = 1'b0;
    o_idx = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (i_req[i]) begin
        o_found = 1'b1;
        o_idx = 4'(i);
      end
    end
  end
endmodule // tlic_poll
`default_nettype wire

// ---- tlic_ctrl.sv ----
// Purpose: Three-tier interrupt controller with core register port
// Assumes: Requests are levels held until the source flag is cleared
// Notes: Core takes an offer with i_core_ack and ends service with i_reti
//
// Contract
// - Twelve sources across three priority tiers
// - Only power monitor sits in top tier
// - Power monitor preempts any running routine
// - Lower tiers set per source by registers, except the watchdog, fixed low
// - High tier preempts a running low routine
// - Simultaneous requests: higher tier granted first
// - No preemption from the same tier
// - Same-tier ties follow fixed polling order
// - Order: monitor, interval, metering, watchdog, temperature...
// - Enable bit 7 gates every source
// - Enable bits 6..0 enable seven sources
// - Tier register bits pick high or low
// - Enable and tier registers are bit addressable
// - Second register resets 0xa0, byte access only
// - Second register: tiers bits 6,4; enables 3..0
// - Deep power-down: wake events restart halted core
// - Enable and tier registers reset to zero
`timescale 1ns/1ps
`default_nettype none
`include "tlic_map.svh"
module tlic_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire tlic_pkg::tlic_sfr_t i_sfr,
  input wire tlic_pkg::tlic_bit_t i_bit,
  input wire logic [9:0] i_periph_req,
  input wire logic [1:0] i_ext_pin,
  input wire logic i_wdt_timeout,
  input wire logic i_core_ack,
  input wire logic i_reti,
  input wire logic i_deep_pd,
  input wire logic i_wake_evt,
  output logic [7:0] o_sfr_rdata,
  output logic o_bit_rdata,
  output tlic_pkg::tlic_offer_t o_offer,
  output logic [2:0] o_in_svc,
  output logic o_core_wake
);
  // ==========================================================
  // Helpers
  // Bit address falls inside a register's eight bit slots
  function automatic logic bit_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction

  // Byte write then bit write onto a bit-addressable register
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] base,
                                     input tlic_pkg::tlic_sfr_t s,
                                     input tlic_pkg::tlic_bit_t b);
    logic [7:0] r;
    r = cur;
    if (s.wr && s.addr == base) begin
      r = s.wdata;
    end
    if (b.wr && bit_hit(b.addr, base)) begin
      r[b.addr[2:0]] = b.val;
    end
    return r;
  endfunction

  // One-hot in-service bit of a tier
  function automatic logic [2:0] tier_bit(input tlic_pkg::tlic_tier_t t);
    return 3'(3'h1 << t);
  endfunction

  // In-service tiers that block an offer at tier t
  function automatic logic [2:0] ge_mask(input tlic_pkg::tlic_tier_t t);
    return 3'(3'h7 << t);
  endfunction

  // ==========================================================
  // State
  logic [7:0] en_ff;
  logic [7:0] ts_ff;
  logic [7:0] x2_ff;
  logic [7:0] wdc_ff;
  logic [2:0] svc_ff;
  tlic_pkg::tlic_offer_t offer_ff;
  logic [7:0] rdata_ff;
  logic bit_rdata_ff;
  logic wake_ff;

  // ==========================================================
  // Request gathering
  wire logic [1:0] ext_lvl;
  tlic_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_pin(i_ext_pin),
    .o_lvl(ext_lvl)
  );

  // External pins take slots 5 and 7 of the polling order
  wire logic [11:0] pend = {i_periph_req[9:6], ext_lvl[1], i_periph_req[5],
                            ext_lvl[0], i_periph_req[4:0]};

  // Per-source enables; the watchdog has only the global gate
  wire logic [11:0] src_en;
  assign src_en[`TLIC_S_PM] = x2_ff[`TLIC_X2_PM_EN];
  assign src_en[`TLIC_S_IT] = x2_ff[`TLIC_X2_IT_EN];
  assign src_en[`TLIC_S_MET] = x2_ff[`TLIC_X2_MET_EN];
  assign src_en[`TLIC_S_WD] = 1'b1;
  assign src_en[`TLIC_S_TEMP] = en_ff[`TLIC_EN_TEMP];
  assign src_en[`TLIC_S_X0] = en_ff[`TLIC_EN_X0];
  assign src_en[`TLIC_S_T0] = en_ff[`TLIC_EN_T0];
  assign src_en[`TLIC_S_X1] = en_ff[`TLIC_EN_X1];
  assign src_en[`TLIC_S_T1] = en_ff[`TLIC_EN_T1];
  assign src_en[`TLIC_S_SP] = x2_ff[`TLIC_X2_SP_EN];
  assign src_en[`TLIC_S_UART] = en_ff[`TLIC_EN_UART];
  assign src_en[`TLIC_S_T2] = en_ff[`TLIC_EN_T2];

  // High-tier selects; monitor slot is never in the lower tiers
  wire logic [11:0] src_hi;
  assign src_hi[`TLIC_S_PM] = 1'b0;
  assign src_hi[`TLIC_S_IT] = x2_ff[`TLIC_X2_TK_TIER];
  assign src_hi[`TLIC_S_MET] = ts_ff[`TLIC_TS_MET];
  assign src_hi[`TLIC_S_WD] = 1'b0;
  assign src_hi[`TLIC_S_TEMP] = ts_ff[`TLIC_TS_TEMP];
  assign src_hi[`TLIC_S_X0] = ts_ff[`TLIC_TS_X0];
  assign src_hi[`TLIC_S_T0] = ts_ff[`TLIC_TS_T0];
  assign src_hi[`TLIC_S_X1] = ts_ff[`TLIC_TS_X1];
  assign src_hi[`TLIC_S_T1] = ts_ff[`TLIC_TS_T1];
  assign src_hi[`TLIC_S_SP] = x2_ff[`TLIC_X2_SP_TIER];
  assign src_hi[`TLIC_S_UART] = ts_ff[`TLIC_TS_UART];
  assign src_hi[`TLIC_S_T2] = ts_ff[`TLIC_TS_T2];

  // Halted core takes no interrupts, only wake events
  wire logic gate = en_ff[`TLIC_EN_GATE] & ~i_deep_pd;
  wire logic [11:0] elig = pend & src_en & {12{gate}};
  wire logic [11:0] top_v = elig & `TLIC_TOP_MASK;
  wire logic [11:0] hi_v = elig & src_hi & ~`TLIC_TOP_MASK;
  wire logic [11:0] lo_v = elig & ~src_hi & ~`TLIC_TOP_MASK;

  // ==========================================================
  // Arbitration
  wire logic top_f;
  wire logic hi_f;
  wire logic lo_f;
  wire logic [3:0] top_i;
  wire logic [3:0] hi_i;
  wire logic [3:0] lo_i;
  tlic_poll u_poll_top (.i_req(top_v), .o_found(top_f), .o_idx(top_i));
  tlic_poll u_poll_hi (.i_req(hi_v), .o_found(hi_f), .o_idx(hi_i));
  tlic_poll u_poll_lo (.i_req(lo_v), .o_found(lo_f), .o_idx(lo_i));

  // A tier may be offered only when no equal or higher tier runs
  wire logic ok_top = top_f & ~svc_ff[2];
  wire logic ok_hi = hi_f & ~|svc_ff[2:1];
  wire logic ok_lo = lo_f & ~|svc_ff;
  wire logic take = i_core_ack & offer_ff.valid;

  // Higher tier wins a tie; an acked offer is withdrawn for a cycle
  tlic_pkg::tlic_offer_t nxt_offer;
  always_comb begin
    nxt_offer = '0;
    if (!take) begin
      if (ok_top) begin
        nxt_offer = '{1'b1, tlic_pkg::TIER_TOP, top_i};
      end else if (ok_hi) begin
        nxt_offer = '{1'b1, tlic_pkg::TIER_HIGH, hi_i};
      end else if (ok_lo) begin
        nxt_offer = '{1'b1, tlic_pkg::TIER_LOW, lo_i};
      end
    end
  end

  // Return ends the innermost routine; a grant opens one
  wire logic [2:0] ret_clr = svc_ff[2] ? 3'h4 : (svc_ff[1] ? 3'h2 : svc_ff);
  wire logic [2:0] svc_kept = i_reti ? (svc_ff & ~ret_clr) : svc_ff;
  wire logic [2:0] nxt_svc = svc_kept | (take ? tier_bit(offer_ff.tier) : 3'h0);

  // ==========================================================
  // Register writes
  wire logic [7:0] nxt_en = upd(en_ff, `TLIC_EN_ADDR, i_sfr, i_bit);
  wire logic [7:0] nxt_ts = upd(ts_ff, `TLIC_TS_ADDR, i_sfr, i_bit);
  wire logic x2_wr = i_sfr.wr && i_sfr.addr == `TLIC_X2_ADDR;
  wire logic [7:0] nxt_x2 = x2_wr ?
    (i_sfr.wdata | `TLIC_X2_RSV) : x2_ff;
  wire logic [7:0] wdc_wr = upd(wdc_ff, `TLIC_WDC_ADDR, i_sfr, i_bit);
  // Timeout flag set beats a software clear in the same cycle
  wire logic [7:0] nxt_wdc = wdc_wr | (i_wdt_timeout ? 8'(8'h01 << `TLIC_WDC_FLAG) : 8'h00);

  // ==========================================================
  // Register reads, answered one cycle later
  logic [7:0] nxt_rdata;
  always_comb begin
    case (i_sfr.addr)
      `TLIC_EN_ADDR: nxt_rdata = en_ff;
      `TLIC_TS_ADDR: nxt_rdata = ts_ff;
      `TLIC_X2_ADDR: nxt_rdata = x2_ff;
      `TLIC_WDC_ADDR: nxt_rdata = wdc_ff;
      default: nxt_rdata = `TLIC_ZERO8;
    endcase
  end

  // Bit reads reach the three bit-addressable registers only
  wire logic [7:0] bit_src = bit_hit(i_bit.addr, `TLIC_EN_ADDR) ? en_ff :
                             bit_hit(i_bit.addr, `TLIC_TS_ADDR) ? ts_ff :
                             bit_hit(i_bit.addr, `TLIC_WDC_ADDR) ? wdc_ff :
                             `TLIC_ZERO8;
  wire logic nxt_bit_rdata = bit_src[i_bit.addr[2:0]];

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      en_ff <= `TLIC_EN_RST;
      ts_ff <= `TLIC_TS_RST;
      x2_ff <= `TLIC_X2_RST;
      wdc_ff <= `TLIC_WDC_RST;
    end else if (i_ce) begin
      en_ff <= nxt_en;
      ts_ff <= nxt_ts;
      x2_ff <= nxt_x2;
      wdc_ff <= nxt_wdc;
    end
  end

  // Service state, offer and read data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      svc_ff <= 3'h0;
      offer_ff <= '0;
      rdata_ff <= `TLIC_ZERO8;
      bit_rdata_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (i_ce) begin
      svc_ff <= nxt_svc;
      offer_ff <= nxt_offer;
      rdata_ff <= i_sfr.rd ? nxt_rdata : rdata_ff;
      bit_rdata_ff <= i_bit.rd ? nxt_bit_rdata : bit_rdata_ff;
      wake_ff <= i_deep_pd & i_wake_evt;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_bit_rdata = bit_rdata_ff;
  assign o_offer = offer_ff;
  assign o_in_svc = svc_ff;
  assign o_core_wake = wake_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_pm_ready;
    i_ce && !take && top_f && !svc_ff[2];
  endsequence
  sequence s_hi_ready;
    i_ce && !take && !top_f && hi_f && svc_ff == 3'h1;
  endsequence

  top_only_pm_a: assert property (
    o_offer.valid && o_offer.tier == tlic_pkg::TIER_TOP |-> o_offer.src == 4'h0)
    else $error("top tier offered a source other than the monitor");
  pm_preempt_a: assert property (
    s_pm_ready |=> o_offer.valid && o_offer.tier == tlic_pkg::TIER_TOP)
    else $error("monitor request did not preempt");
  hi_over_lo_a: assert property (
    s_hi_ready |=> o_offer.valid && o_offer.tier == tlic_pkg::TIER_HIGH)
    else $error("high request did not preempt low routine");
  tie_tier_a: assert property (
    i_ce && !take && hi_f && lo_f && !top_f && svc_ff == 3'h0
    |=> o_offer.tier == tlic_pkg::TIER_HIGH)
    else $error("low tier won over a simultaneous high request");
  no_same_tier_a: assert property (
    o_offer.valid |-> (svc_ff & ge_mask(o_offer.tier)) == 3'h0)
    else $error("offer made while its own tier is in service");
  poll_order_a: assert property (
    $past(i_ce) && o_offer.valid && o_offer.tier == tlic_pkg::TIER_LOW
    |-> ($past(lo_v) & 12'((`TLIC_ONE12 << o_offer.src) - `TLIC_ONE12)) == 12'h000)
    else $error("earlier slot in the polling order was skipped");
  gate_off_a: assert property (
    i_ce && !en_ff[`TLIC_EN_GATE] |=> !o_offer.valid)
    else $error("offer made with the global gate off");
  bit_wr_a: assert property (
    i_ce && i_bit.wr && !i_sfr.wr && bit_hit(i_bit.addr, `TLIC_EN_ADDR)
    |=> en_ff[$past(i_bit.addr[2:0])] == $past(i_bit.val))
    else $error("bit write did not reach the enable register");
  x2_rsv_a: assert property (
    (x2_ff & `TLIC_X2_RSV) == `TLIC_X2_RSV)
    else $error("reserved bits of the second register changed");
  pd_wake_a: assert property (
    i_ce && i_deep_pd |=> !o_offer.valid && o_core_wake == $past(i_wake_evt))
    else $error("deep power-down offer or wake mismatch");
  rst_val_a: assert property (
    $rose(i_rst_n) |-> en_ff == `TLIC_EN_RST && ts_ff == `TLIC_TS_RST
    && x2_ff == `TLIC_X2_RST)
    else $error("registers not at reset values");
  grant_a: assert property (
    i_ce && take |=> (svc_ff & tier_bit($past(offer_ff.tier))) != 3'h0 && !o_offer.valid)
    else $error("grant did not open a routine");
endmodule // tlic_ctrl
`default_nettype wire

// ---- tlic_core_model.sv ----
// Purpose: Core-side partner that takes offers from the controller
// Assumes: Offer is a registered level, ack is taken on the rising edge
// Notes: Slow mode lets an offer stand a few cycles before taking it
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire tlic_pkg::tlic_offer_t i_offer,
  input wire logic i_slow,
  output logic o_ack,
  output logic [7:0] o_taken,
  output logic [3:0] o_src,
  output logic [1:0] o_tier
);
  logic ack_ff;
  logic [1:0] hold_ff;

  // ==========================================================
  // Ack on the falling edge, held one full cycle, so it is stable at sampling
  always @(negedge i_clk) begin
    if (!i_rst_n || ack_ff) begin
      ack_ff <= 1'b0;
      hold_ff <= 2'h0;
    end else if (i_offer.valid === 1'b1) begin
      if (i_slow && hold_ff != 2'h3) begin
        hold_ff <= hold_ff + 2'h1;
      end else begin
        ack_ff <= 1'b1;
      end
    end
  end
  assign o_ack = ack_ff;

  // ==========================================================
  // Note the winning source, as the core would to pick its vector
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_taken <= 8'h00;
      o_src <= 4'h0;
      o_tier <= 2'h0;
    end else if (ack_ff && i_offer.valid) begin
      o_taken <= o_taken + 8'h01;
      o_src <= i_offer.src;
      o_tier <= i_offer.tier;
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// ---- tlic_ctrl_tb.sv ----
// Purpose: Self-checking bench for the three-tier interrupt controller
// Assumes: Core side played by tlic_core_model
// Notes: Inputs change on the falling edge; i_ce is held high
`timescale 1ns/1ps
`default_nettype none
`include "tlic_map.svh"
module tlic_ctrl_tb;
  logic i_clk, i_rst_n, reti, deep_pd, wake, wdt, slow, ack, bit_rdata, core_wake;
  tlic_pkg::tlic_sfr_t sfr;
  tlic_pkg::tlic_bit_t bacc;
  tlic_pkg::tlic_offer_t offer;
  logic [9:0] preq;
  logic [1:0] ext, got_tier;
  logic [7:0] rdata, taken;
  logic [3:0] got_src;
  logic [2:0] in_svc;
  int error_cnt = 0;
  int checks_done = 0;

  tlic_ctrl tlic_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_sfr(sfr),
    .i_bit(bacc), .i_periph_req(preq), .i_ext_pin(ext), .i_wdt_timeout(wdt),
    .i_core_ack(ack), .i_reti(reti), .i_deep_pd(deep_pd), .i_wake_evt(wake),
    .o_sfr_rdata(rdata), .o_bit_rdata(bit_rdata), .o_offer(offer), .o_in_svc(in_svc),
    .o_core_wake(core_wake));
  tlic_core_model tlic_core_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_offer(offer),
    .i_slow(slow), .o_ack(ack), .o_taken(taken), .o_src(got_src), .o_tier(got_tier));

  // ==========================================================
  // Clock and shared tasks
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk) sfr = {1'b1, 1'b0, a, d};
    @(negedge i_clk) sfr = '0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk) sfr = {1'b0, 1'b1, a, 8'h00};
    @(negedge i_clk) sfr = '0;
    @(negedge i_clk) check(rdata, exp);
  endtask
  task automatic bit_wr(input logic [7:0] a, input logic d);
    @(negedge i_clk) bacc = {1'b1, 1'b0, a, d};
    @(negedge i_clk) bacc = '0;
  endtask
  // Wait for the core to take an offer, then judge what it took
  task automatic take(input logic [3:0] src, input logic [1:0] tier, input logic [2:0] svc);
    logic [7:0] t0;
    int n;
    t0 = taken;
    n = 0;
    while (taken === t0 && n < 60) begin
      @(negedge i_clk);
      n++;
    end
    check(taken !== t0, 1'b1);
    check(got_src, src);
    check(got_tier, tier);
    check(in_svc, svc);
  endtask
  // No offer may be taken over a span of eight cycles
  task automatic idle_chk;
    logic [7:0] t0;
    t0 = taken;
    repeat (8) @(negedge i_clk);
    check(taken, t0);
    check(offer.valid, 1'b0);
  endtask
  // Drop a slot's request, let the pin filter settle, then return
  task automatic finish_src(input int s);
    @(negedge i_clk);
    if (s == 5) ext[0] = 1'b0;
    else if (s == 7) ext[1] = 1'b0;
    else preq[(s < 5) ? s : (s == 6) ? 5 : s - 2] = 1'b0;
    repeat (6) @(negedge i_clk);
    reti = 1'b1;
    @(negedge i_clk) reti = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_vals;
    sfr_rd(`TLIC_EN_ADDR, 8'h00);
    sfr_rd(`TLIC_TS_ADDR, 8'h00);
    sfr_rd(`TLIC_X2_ADDR, 8'ha0);
    sfr_rd(`TLIC_WDC_ADDR, 8'h10);
    sfr_rd(8'h55, 8'h00);
  endtask

  task automatic t_reg_access;
    sfr_wr(`TLIC_EN_ADDR, 8'h85);
    sfr_rd(`TLIC_EN_ADDR, 8'h85);
    bit_wr(8'ha9, 1'b1);
    sfr_rd(`TLIC_EN_ADDR, 8'h87);
    bit_wr(8'hbf, 1'b1);
    sfr_rd(`TLIC_TS_ADDR, 8'h80);
    @(negedge i_clk) bacc = {1'b0, 1'b1, 8'haf, 1'b0};
    @(negedge i_clk) bacc = '0;
    @(negedge i_clk) check(bit_rdata, 1'b1);
    sfr_wr(`TLIC_X2_ADDR, 8'h5f);
    sfr_rd(`TLIC_X2_ADDR, 8'hff);
    @(negedge i_clk) wdt = 1'b1;
    @(negedge i_clk) wdt = 1'b0;
    sfr_rd(`TLIC_WDC_ADDR, 8'h14);
  endtask

  task automatic t_poll;
    slow = 1'b1;
    sfr_wr(`TLIC_EN_ADDR, 8'hff);
    sfr_wr(`TLIC_X2_ADDR, 8'h0f);
    sfr_wr(`TLIC_TS_ADDR, 8'h00);
    @(negedge i_clk);
    preq = 10'h3ff;
    ext = 2'h3;
    for (int i = 0; i < 12; i++) begin
      take(i[3:0], (i == 0) ? 2'h2 : 2'h0, (i == 0) ? 3'h4 : 3'h1);
      finish_src(i);
    end
    slow = 1'b0;
  endtask

  task automatic t_preempt;
    sfr_wr(`TLIC_TS_ADDR, 8'h02);
    @(negedge i_clk) preq[8] = 1'b1;
    take(4'ha, 2'h0, 3'h1);
    @(negedge i_clk) preq[6] = 1'b1;
    idle_chk();
    @(negedge i_clk) preq[5] = 1'b1;
    take(4'h6, 2'h1, 3'h3);
    @(negedge i_clk) preq[0] = 1'b1;
    take(4'h0, 2'h2, 3'h7);
    finish_src(0);
    check(in_svc, 3'h3);
    finish_src(6);
    finish_src(10);
    take(4'h8, 2'h0, 3'h1);
    finish_src(8);
  endtask

  task automatic t_same_cycle;
    sfr_wr(`TLIC_TS_ADDR, 8'h10);
    @(negedge i_clk);
    preq[4] = 1'b1;
    preq[8] = 1'b1;
    take(4'ha, 2'h1, 3'h2);
    finish_src(10);
    take(4'h4, 2'h0, 3'h1);
    finish_src(4);
  endtask

  task automatic t_gate;
    bit_wr(8'had, 1'b0);
    @(negedge i_clk) preq[9] = 1'b1;
    idle_chk();
    bit_wr(8'haf, 1'b0);
    bit_wr(8'had, 1'b1);
    idle_chk();
    @(negedge i_clk) deep_pd = 1'b1;
    bit_wr(8'haf, 1'b1);
    idle_chk();
    @(negedge i_clk) wake = 1'b1;
    @(negedge i_clk) check(core_wake, 1'b1);
    deep_pd = 1'b0;
    // A wake event while the core runs must not raise the wake output
    @(negedge i_clk) check(core_wake, 1'b0);
    wake = 1'b0;
    take(4'hb, 2'h0, 3'h1);
    finish_src(11);
  endtask

  // Reset in mid-run, after every register has been written
  task automatic t_mid_reset;
    @(negedge i_clk) i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset_vals();
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    i_rst_n = 1'b0;
    sfr = '0;
    bacc = '0;
    preq = 10'h000;
    ext = 2'h0;
    {reti, deep_pd, wake, wdt, slow} = 5'h00;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_reset_vals();
    t_reg_access();
    t_poll();
    t_preempt();
    t_same_cycle();
    t_gate();
    t_mid_reset();
    give_verdict();
  end

  // Whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    give_verdict();
  end
endmodule // tlic_ctrl_tb
`default_nettype wire
